/* File: hdl/hpps_pkg.sv */
package hpps_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] PORT6_POWER_SOURCE_SELECT_OFFSET = 16'h3c14;
    localparam logic [15:0] PORT7_POWER_SOURCE_SELECT_OFFSET = 16'h3c18;
    localparam int ADDR_WIDTH = 16;
    localparam int NUM_PORTS = 2;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int SHARED_PIN_BIT = 7;
    localparam int RESERVED_BIT = 6;
    localparam int PORT_DISABLE_BIT = 5;
    localparam int FIXED_DEVICE_BIT = 4;
    localparam int SOURCE_MSB = 3;
    localparam int SOURCE_LSB = 0;
    localparam logic [7:0] WRITABLE_MASK = 8'hbf;
    localparam logic [7:0] SELECT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Power source encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_USB2 = 4'h1;
    localparam logic [3:0] SRC_USB3 = 4'h2;
    localparam logic [3:0] SRC_EITHER = 4'h3;
    localparam logic [3:0] SRC_GPIO = 4'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Upstream power requests for one port
    typedef struct packed {
        logic usb2_power;
        logic usb3_power;
        logic gpio_power;
    } hpps_power_req_s;

    // Decoded port configuration seen by the hub logic
    typedef struct packed {
        logic port_power;
        logic shared_pins;
        logic port_disabled;
        logic fixed_attached_device;
    } hpps_port_ctl_s;

endpackage

/* File: hdl/hpps_port_decode.sv */
// Turns one select register and the upstream power levels into port controls.
module hpps_port_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] select,
    input wire hpps_pkg::hpps_power_req_s req,
    output hpps_pkg::hpps_port_ctl_s ctl
);

    logic [3:0] power_source_choice;
    logic next_power;

    assign power_source_choice = select[hpps_pkg::SOURCE_MSB:hpps_pkg::SOURCE_LSB];

    // Reserved codes keep power off, so a bad load cannot power a port
    assign next_power =
        (power_source_choice == hpps_pkg::SRC_USB2)   ? req.usb2_power :
        (power_source_choice == hpps_pkg::SRC_USB3)   ? req.usb3_power :
        (power_source_choice == hpps_pkg::SRC_EITHER) ? (req.usb2_power | req.usb3_power) :
        (power_source_choice == hpps_pkg::SRC_GPIO)   ? req.gpio_power :
        1'b0; // [R4]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= '0;
        end else begin
            ctl.port_power <= next_power & ~select[hpps_pkg::PORT_DISABLE_BIT]; // [R4] [R2]
            ctl.shared_pins <= select[hpps_pkg::SHARED_PIN_BIT]; // [R1]
            ctl.port_disabled <= select[hpps_pkg::PORT_DISABLE_BIT]; // [R2]
            ctl.fixed_attached_device <= select[hpps_pkg::FIXED_DEVICE_BIT]; // [R3]
        end
    end

endmodule

/* File: hdl/hpps_top.sv */
// Function
// [R1] Bit 7 set means port power and over-current sense share pins, clear means separate pins.
// [R2] Bit 5 set disables the port and reports it to the hub as permanently unavailable.
// [R3] Bit 4 set marks the port as having a permanently attached, non-removable device.
// [R4] Bits 3:0 pick power source: off, USB2, USB3, either, or the designated GPIO.
// [R5] Software writes only the defined source encodings; the rest are reserved.
// [R6] The settings come from the configuration load and are not changed during operation.
// [R7] Disable, fixed device and shared-pin bits are loaded before the hub enumerates.
// [R8] Bit 6 reads zero and ignores writes; the other fields read back what was written.
//
// Our own choice: the AXI4-Lite register port.
module hpps_top #(
    parameter int NUM_PORTS = hpps_pkg::NUM_PORTS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire hpps_pkg::hpps_power_req_s [1:0] power_req,
    output hpps_pkg::hpps_port_ctl_s [1:0] port_ctl
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // Only two select registers exist in the map, so no other count can work
    if (NUM_PORTS != 2) begin : g_bad_ports
        $error("hpps_top serves exactly two ports");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [1:0] reg_hit(input logic [15:0] addr);
        reg_hit[0] = (addr == hpps_pkg::PORT6_POWER_SOURCE_SELECT_OFFSET);
        reg_hit[1] = (addr == hpps_pkg::PORT7_POWER_SOURCE_SELECT_OFFSET);
    endfunction

    logic [7:0] select [2];
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;

    // ------------------------------------------------------------------
    // Handshake terms
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire b_take = s_axi_bvalid & s_axi_bready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_take = s_axi_rvalid & s_axi_rready;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire [1:0] wr_hit = reg_hit(aw_addr);
    wire wr_mapped = |wr_hit;
    wire wr_low_byte = w_strb[0];
    wire [7:0] wr_byte = w_data[7:0] & hpps_pkg::WRITABLE_MASK; // [R8]

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    wire [7:0] rd_part [2];
    wire [1:0] rd_hit = reg_hit(s_axi_araddr);
    wire rd_mapped = |rd_hit;
    // AND-OR mux: a miss leaves every part at zero, so unmapped reads return zero
    wire [7:0] rd_byte = rd_part[0] | rd_part[1];

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    wire next_aw_held = do_write ? 1'b0 : (aw_held | aw_take);
    wire next_w_held = do_write ? 1'b0 : (w_held | w_take);
    // Ready drops the cycle after a take, so a held item is never overwritten
    wire next_awready = ~aw_held & ~aw_take & ~s_axi_bvalid;
    wire next_wready = ~w_held & ~w_take & ~s_axi_bvalid;
    wire next_bvalid = do_write | (s_axi_bvalid & ~b_take);
    wire [1:0] next_bresp = wr_mapped ? hpps_pkg::RESP_OKAY : hpps_pkg::RESP_SLVERR;

    // Address and data are caught separately so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
        end else begin
            w_held <= next_w_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 16'h0000;
        end else if (aw_take) begin
            aw_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= next_awready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= next_wready;
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    // Unmapped writes still answer, with an error code, so no master hangs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hpps_pkg::RESP_OKAY;
        end else begin
            s_axi_bvalid <= next_bvalid;
            if (do_write) begin
                s_axi_bresp <= next_bresp;
            end
        end
    end

    // ------------------------------------------------------------------
    // Select registers
    // ------------------------------------------------------------------
    // Values are not screened: reserved source codes are the loader's
    // concern and simply decode to power off. [R5]
    // No lock is kept against live rewrites; the loader owns that. [R6] [R7]
    wire [1:0] reg_we;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Only the low byte carries the register, so only its strobe counts
            assign reg_we[p] = do_write & wr_hit[p] & wr_low_byte;
            assign rd_part[p] = rd_hit[p] ? select[p] : 8'h00; // [R8]

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    select[p] <= hpps_pkg::SELECT_RESET;
                end else if (reg_we[p]) begin
                    select[p] <= wr_byte; // [R8]
                end
            end

            hpps_port_decode u_decode (
                .aclk(aclk),
                .aresetn(aresetn),
                .select(select[p]),
                .req(power_req[p]),
                .ctl(port_ctl[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire next_arready = ~s_axi_rvalid & ~ar_take;
    wire next_rvalid = ar_take | (s_axi_rvalid & ~r_take);
    wire [31:0] next_rdata = {24'h000000, rd_byte}; // [R8]
    wire [1:0] next_rresp = rd_mapped ? hpps_pkg::RESP_OKAY : hpps_pkg::RESP_SLVERR;

    // One read at a time: the address is refused until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // Data and code are caught with the address and stand until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= hpps_pkg::RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule

/* File: sim/hpps_assertions.sv */
// ------------------------------------------------
// Port control and register read checks
// ------------------------------------------------
module hpps_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire hpps_pkg::hpps_power_req_s [1:0] power_req,
    input wire hpps_pkg::hpps_port_ctl_s [1:0] port_ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Config bits may only move right after a write lands
    shared_pins_a: assert property (
        $changed(port_ctl[0].shared_pins) |-> $past(s_axi_bvalid))
        else $error("shared pin mode moved without a write");
    disable_off_a: assert property (
        port_ctl[0].port_disabled |-> !port_ctl[0].port_power)
        else $error("disabled port still powered");
    fixed_device_a: assert property (
        $changed(port_ctl[1].fixed_attached_device) |-> $past(s_axi_bvalid))
        else $error("fixed device flag moved without a write");
    power_cause_a: assert property (
        port_ctl[1].port_power |-> $past(power_req[1]) != '0)
        else $error("port power on with no request");
    reserved_zero_a: assert property (
        s_axi_rvalid |-> (s_axi_rdata & 32'hffffff40) == 32'h0)
        else $error("reserved read bits not zero");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (port_ctl[1].port_power);
    cover property (port_ctl[0].port_disabled);
endmodule

/* File: sim/hpps_hub_model.sv */
// ------------------------------------------------
// Upstream hub power logic
// ------------------------------------------------
module hpps_hub_model (
    input wire logic aclk,
    input wire logic [5:0] levels,
    output hpps_pkg::hpps_power_req_s [1:0] power_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Requests come from registered logic, so they move only on the clock
    always_ff @(posedge aclk) begin
        power_req <= levels;
    end
endmodule

/* File: sim/testbench.sv */
// ------------------------------------------------
// Power select bench
// ------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] P6 = hpps_pkg::PORT6_POWER_SOURCE_SELECT_OFFSET;
    localparam logic [15:0] P7 = hpps_pkg::PORT7_POWER_SOURCE_SELECT_OFFSET;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0, rdata, data;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [5:0] levels = 6'h0;
    hpps_pkg::hpps_power_req_s [1:0] power_req;
    hpps_pkg::hpps_port_ctl_s [1:0] port_ctl;
    int n_mismatch = 0, checked = 0;
    always #20 aclk = ~aclk;
    hpps_hub_model hub (.aclk(aclk), .levels(levels), .power_req(power_req));
    hpps_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_req(power_req),
        .port_ctl(port_ctl));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic give_up(input int i);
        if (i >= 40) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Each channel is released at the edge that takes it, never earlier
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] d);
        int i;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        give_up(i);
        resp = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [15:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        give_up(i);
        resp = rresp;
        data = rdata;
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic check_fields();
        axi_rd(P6);
        chk("port6 reset", 32'h0, data);
        levels <= 6'h07;
        axi_wr(P6, 8'hf3);
        axi_rd(P6);
        chk("port6 readback", 32'hb3, data);
        repeat (3) @(posedge aclk);
        chk("port6 disabled ctl", 32'h7, 32'(port_ctl[0]));
        axi_wr(P6, 8'h83);
        repeat (3) @(posedge aclk);
        chk("port6 enabled ctl", 32'hc, 32'(port_ctl[0]));
    endtask
    task automatic check_sources();
        logic on;
        axi_wr(P7, 8'h50);
        axi_rd(P7);
        chk("port7 readback", 32'h10, data);
        for (int c = 0; c < 5; c++) begin
            axi_wr(P7, 8'(c));
            for (int j = 0; j < 8; j++) begin
                levels <= {3'(j), 3'h0};
                repeat (3) @(posedge aclk);
                on = c == 0 ? 1'h0 : c == 1 ? j[2] : c == 2 ? j[1] : c == 3 ? j[2] | j[1] : j[0];
                chk("port7 power", 32'(on), 32'(port_ctl[1].port_power));
            end
        end
    endtask
    task automatic check_unmapped();
        axi_wr(16'h3c1c, 8'hff);
        chk("unmapped bresp", 32'h2, 32'(resp));
        axi_rd(16'h3c1c);
        chk("unmapped rresp", 32'h2, 32'(resp));
        chk("unmapped rdata", 32'h0, data);
        axi_rd(P7);
        chk("port7 kept", 32'h4, data);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check_fields();
        check_sources();
        check_unmapped();
        tally_and_finish();
    end
endmodule
bind hpps_top hpps_checker chk_i (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_rdata,
    .s_axi_rvalid, .power_req, .port_ctl);
